// ### rtl/pdc_pkg.sv
package pdc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] PDC_IDX_BACKUP_CHARGER   = 8'h39;
    localparam logic [7:0] PDC_IDX_CONVERTER        = 8'h3e;
    localparam logic [7:0] PDC_IDX_DEVICE_STATE     = 8'h3f;
    localparam int         PDC_ADDR_LSB             = 2;

    // Back-up charger fields
    localparam int         PDC_BB_ENABLE_BIT        = 0;
    localparam int         PDC_BB_VSEL_LSB          = 1;
    localparam logic [1:0] PDC_BB_VSEL_RST          = 2'h0;
    localparam logic       PDC_BB_ENABLE_RST        = 1'h0;

    // Converter control fields
    localparam int         PDC_CV_SYNC_LSB          = 0;
    localparam int         PDC_CV_EXT_CLK_BIT       = 2;
    localparam int         PDC_CV_IO_PSKIP_BIT      = 3;
    localparam int         PDC_CV_CORE1_PSKIP_BIT   = 4;
    localparam int         PDC_CV_CORE2_PSKIP_BIT   = 5;
    localparam int         PDC_CV_TRACK_BIT         = 6;
    localparam logic [1:0] PDC_CV_SYNC_RST          = 2'h1;
    localparam logic [1:0] PDC_CV_SYNC_PHASE_SHIFT  = 2'h1;
    localparam logic       PDC_CV_EXT_CLK_RST       = 1'h0;
    localparam logic [2:0] PDC_CV_PSKIP_RST         = 3'h7;
    localparam logic       PDC_CV_TRACK_RST         = 1'h0;

    // Device state control fields
    localparam int         PDC_DS_OFF_BIT           = 0;
    localparam int         PDC_DS_SLEEP_BIT         = 1;
    localparam int         PDC_DS_KEEP_ON_BIT       = 2;
    localparam int         PDC_DS_OFF_RST_BIT       = 3;
    localparam int         PDC_DS_PORT_SEL_BIT      = 4;
    localparam int         PDC_DS_SLOW_CLK_BIT      = 5;
    localparam int         PDC_DS_RTC_PD_BIT        = 6;
    localparam int         PDC_DS_SEQ_OFF_BIT       = 7;
    localparam logic [7:0] PDC_DS_RST               = 8'h10;

endpackage : pdc_pkg

// ### rtl/pdc_control_regs.sv
// Notes on behaviour
// - Two-bit back-up charge voltage select, resets zero
// - Bit zero enables back-up charging, resets zero
// - Tracking bit makes regulator four follow core one
// - Three pulse-skip enables, reset one, boot loaded
// - External clock select muxes second general pin
// - Sync field: 01 phase shift, 11 in phase, 00 and 10 none
// - Upper bits turn-off reset, lower general only
// - Sequential power-off bit selects reverse order
// - RTC power-down gates clock; survives backup state
// - Slow clock source select, boot loaded
// - Scaling port select, resets one
// - Off-with-reset starts off, resets core, cleared in off
// - Keep-on holds device on without off requests
// - Sleep-allow permits sleep, cleared in off
// - Writing sleep-allow zero triggers wake-up
// - Switch-off starts off, cleared in off
`timescale 1ns/1ps

module pdc_control_regs
    import pdc_pkg::*;
(
    // Clock and resets
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_turnoff_rst_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    // Boot configuration load
    input  wire logic        i_boot_load,
    input  wire logic [2:0]  i_boot_pulse_skip,
    input  wire logic        i_boot_slow_clock_source,
    input  wire logic        i_boot_keep_on,
    // Device status
    input  wire logic        i_off_state,
    input  wire logic        i_backup_state,
    input  wire logic        i_core_supply_one_active,
    input  wire logic        i_second_general_pin_in,
    // Back-up charger
    output logic             o_backup_charge_enable,
    output logic [1:0]       o_backup_charge_voltage_select,
    // Converters
    output logic             o_linear_regulator_four_track,
    output logic             o_core_two_pulse_skip,
    output logic             o_core_one_pulse_skip,
    output logic             o_io_converter_pulse_skip,
    output logic             o_second_general_pin_gpio_en,
    output logic             o_converter_ext_clock,
    output logic             o_converter_clock_sync,
    output logic             o_converter_clock_phase_shift,
    // Device state
    output logic             o_sequential_power_off,
    output logic             o_rtc_clock_enable,
    output logic             o_rtc_reset,
    output logic             o_slow_clock_source_select,
    output logic             o_scaling_port_select,
    output logic             o_keep_on_request,
    output logic             o_sleep_allow,
    output logic             o_switch_off_event,
    output logic             o_core_reset_request,
    output logic             o_wake_up_event
);

    logic [1:0]  bb_vsel_r;
    logic        bb_en_r;
    logic        cv_track_r;
    logic [2:0]  cv_pskip_r;
    logic        cv_ext_clk_r;
    logic [1:0]  cv_sync_r;
    logic [7:0]  ds_r;
    logic [7:0]  ds_nxt;
    logic [7:0]  rd_data;
    logic        rd_hit;
    logic [5:0]  idx;
    logic        idx_ok;
    logic        access;
    logic        wr_en;
    logic        wr_bb;
    logic        wr_cv;
    logic        wr_ds;
    logic [7:0]  wbyte;
    logic        off_pending;

    // Bus decode
    assign idx    = i_paddr[7:PDC_ADDR_LSB];
    assign idx_ok = (i_paddr[PDC_ADDR_LSB-1:0] == 2'h0);
    assign access = i_psel && i_penable && o_pready;
    assign wr_en  = access && i_pwrite && i_pstrb[0] && idx_ok;
    assign wbyte  = i_pwdata[7:0];
    assign wr_bb  = wr_en && (idx == PDC_IDX_BACKUP_CHARGER[5:0]);
    assign wr_cv  = wr_en && (idx == PDC_IDX_CONVERTER[5:0]);
    assign wr_ds  = wr_en && (idx == PDC_IDX_DEVICE_STATE[5:0]);

    always_comb
    begin
        rd_data = 8'h00;
        rd_hit  = idx_ok;
        case (idx)
            PDC_IDX_BACKUP_CHARGER[5:0]:
            begin
                rd_data[PDC_BB_VSEL_LSB +: 2]  = bb_vsel_r;
                rd_data[PDC_BB_ENABLE_BIT]     = bb_en_r;
            end
            PDC_IDX_CONVERTER[5:0]:
            begin
                rd_data[PDC_CV_TRACK_BIT]       = cv_track_r;
                rd_data[PDC_CV_CORE2_PSKIP_BIT] = cv_pskip_r[2];
                rd_data[PDC_CV_CORE1_PSKIP_BIT] = cv_pskip_r[1];
                rd_data[PDC_CV_IO_PSKIP_BIT]    = cv_pskip_r[0];
                rd_data[PDC_CV_EXT_CLK_BIT]     = cv_ext_clk_r;
                rd_data[PDC_CV_SYNC_LSB +: 2]   = cv_sync_r;
            end
            PDC_IDX_DEVICE_STATE[5:0]:
            begin
                rd_data = ds_r;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
        // Unaligned offsets alias a register; refuse them with zero data
        if (!rd_hit)
        begin
            rd_data = 8'h00;
        end
    end

    // Zero-wait answer: ready rises in the first access cycle
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !rd_hit;
            if (i_psel && !i_penable && !i_pwrite)
            begin
                o_prdata <= {24'h00_0000, rd_data};
            end
        end
    end

    // Back-up charger, general reset only
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            bb_vsel_r <= PDC_BB_VSEL_RST;
            bb_en_r   <= PDC_BB_ENABLE_RST;
        end
        else if (wr_bb)
        begin
            bb_vsel_r <= wbyte[PDC_BB_VSEL_LSB +: 2];
            bb_en_r   <= wbyte[PDC_BB_ENABLE_BIT];
        end
    end

    // Converter upper bits also fall to the turn-off reset
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || !i_turnoff_rst_n)
        begin
            cv_track_r <= PDC_CV_TRACK_RST;
            cv_pskip_r <= PDC_CV_PSKIP_RST;
        end
        else if (i_boot_load)
        begin
            cv_pskip_r <= i_boot_pulse_skip;
        end
        else if (wr_cv)
        begin
            cv_track_r    <= wbyte[PDC_CV_TRACK_BIT];
            cv_pskip_r[2] <= wbyte[PDC_CV_CORE2_PSKIP_BIT];
            cv_pskip_r[1] <= wbyte[PDC_CV_CORE1_PSKIP_BIT];
            cv_pskip_r[0] <= wbyte[PDC_CV_IO_PSKIP_BIT];
        end
    end

    // Converter lower bits ignore the turn-off reset
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cv_ext_clk_r <= PDC_CV_EXT_CLK_RST;
            cv_sync_r    <= PDC_CV_SYNC_RST;
        end
        else if (wr_cv)
        begin
            cv_ext_clk_r <= wbyte[PDC_CV_EXT_CLK_BIT];
            cv_sync_r    <= wbyte[PDC_CV_SYNC_LSB +: 2];
        end
    end

    // Device state next value; a write of one beats the clear in OFF
    always_comb
    begin
        ds_nxt = ds_r;
        if (i_boot_load)
        begin
            ds_nxt[PDC_DS_SLOW_CLK_BIT] = i_boot_slow_clock_source;
            ds_nxt[PDC_DS_KEEP_ON_BIT]  = i_boot_keep_on;
        end
        else if (wr_ds)
        begin
            ds_nxt = wbyte;
        end
        if (i_off_state)
        begin
            if (!(wr_ds && wbyte[PDC_DS_OFF_BIT]))
            begin
                ds_nxt[PDC_DS_OFF_BIT] = 1'b0;
            end
            if (!(wr_ds && wbyte[PDC_DS_OFF_RST_BIT]))
            begin
                ds_nxt[PDC_DS_OFF_RST_BIT] = 1'b0;
            end
            if (!(wr_ds && wbyte[PDC_DS_SLEEP_BIT]))
            begin
                ds_nxt[PDC_DS_SLEEP_BIT] = 1'b0;
            end
        end
    end

    // RTC power-down is kept when reset comes from the backup state
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            ds_r[PDC_DS_SEQ_OFF_BIT:PDC_DS_RTC_PD_BIT+1] <= PDC_DS_RST[7:7];
            ds_r[PDC_DS_RTC_PD_BIT-1:0]                  <= PDC_DS_RST[5:0];
            if (!i_backup_state)
            begin
                ds_r[PDC_DS_RTC_PD_BIT] <= PDC_DS_RST[PDC_DS_RTC_PD_BIT];
            end
        end
        else
        begin
            ds_r <= ds_nxt;
        end
    end

    // Either switch-off request masks keep-on, sleep and wake-up
    assign off_pending = ds_r[PDC_DS_OFF_BIT] || ds_r[PDC_DS_OFF_RST_BIT];

    // Transition events, one cycle each
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_switch_off_event   <= 1'b0;
            o_core_reset_request <= 1'b0;
            o_wake_up_event      <= 1'b0;
        end
        else
        begin
            o_switch_off_event   <= wr_ds && (wbyte[PDC_DS_OFF_BIT]
                                    || wbyte[PDC_DS_OFF_RST_BIT]);
            o_core_reset_request <= wr_ds && wbyte[PDC_DS_OFF_RST_BIT];
            o_wake_up_event      <= wr_ds && !off_pending
                                    && !wbyte[PDC_DS_SLEEP_BIT]
                                    && !wbyte[PDC_DS_OFF_BIT]
                                    && !wbyte[PDC_DS_OFF_RST_BIT];
        end
    end

    // Control levels to the analogue and sequencer side
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_backup_charge_enable         <= 1'b0;
            o_backup_charge_voltage_select <= 2'h0;
            o_linear_regulator_four_track  <= 1'b0;
            o_core_two_pulse_skip          <= 1'b0;
            o_core_one_pulse_skip          <= 1'b0;
            o_io_converter_pulse_skip      <= 1'b0;
            o_second_general_pin_gpio_en   <= 1'b1;
            o_converter_ext_clock          <= 1'b0;
            o_converter_clock_sync         <= 1'b0;
            o_converter_clock_phase_shift  <= 1'b0;
        end
        else
        begin
            o_backup_charge_enable         <= bb_en_r;
            o_backup_charge_voltage_select <= bb_vsel_r;
            o_linear_regulator_four_track  <= cv_track_r
                                              && i_core_supply_one_active;
            o_core_two_pulse_skip          <= cv_pskip_r[2];
            o_core_one_pulse_skip          <= cv_pskip_r[1];
            o_io_converter_pulse_skip      <= cv_pskip_r[0];
            o_second_general_pin_gpio_en   <= !cv_ext_clk_r;
            o_converter_ext_clock          <= cv_ext_clk_r
                                              && i_second_general_pin_in;
            o_converter_clock_sync         <= cv_sync_r[0];
            o_converter_clock_phase_shift  <= (cv_sync_r == PDC_CV_SYNC_PHASE_SHIFT);
        end
    end

    // Device state levels; keep-on and sleep yield to off requests
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_sequential_power_off     <= 1'b0;
            o_rtc_clock_enable         <= 1'b1;
            o_rtc_reset                <= 1'b0;
            o_slow_clock_source_select <= 1'b0;
            o_scaling_port_select      <= 1'b1;
            o_keep_on_request          <= 1'b0;
            o_sleep_allow              <= 1'b0;
        end
        else
        begin
            o_sequential_power_off     <= ds_r[PDC_DS_SEQ_OFF_BIT];
            o_rtc_clock_enable         <= !ds_r[PDC_DS_RTC_PD_BIT];
            o_rtc_reset                <= ds_r[PDC_DS_RTC_PD_BIT];
            o_slow_clock_source_select <= ds_r[PDC_DS_SLOW_CLK_BIT];
            o_scaling_port_select      <= ds_r[PDC_DS_PORT_SEL_BIT];
            o_keep_on_request          <= ds_r[PDC_DS_KEEP_ON_BIT]
                                          && !off_pending;
            o_sleep_allow              <= ds_r[PDC_DS_SLEEP_BIT]
                                          && !off_pending;
        end
    end

endmodule : pdc_control_regs

// ### verification/pdc_control_regs_monitor.sv
`timescale 1ns/1ps

module pdc_control_regs_monitor
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    // Block outputs and core one status input
    input wire logic        i_core_supply_one_active,
    input wire logic        o_linear_regulator_four_track,
    input wire logic        o_second_general_pin_gpio_en,
    input wire logic        o_converter_ext_clock,
    input wire logic        o_converter_clock_sync,
    input wire logic        o_converter_clock_phase_shift,
    input wire logic        o_rtc_clock_enable,
    input wire logic        o_rtc_reset,
    input wire logic        o_switch_off_event,
    input wire logic        o_core_reset_request,
    input wire logic        o_wake_up_event
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    logic setup;
    logic off_wr;
    assign setup  = i_psel && !i_penable;
    assign off_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'hfc
                    && i_pstrb[0] && i_pwdata[0];

    chk_ready_after_setup: assert property (setup |=> o_pready)
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    chk_rdata_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_slverr_unmapped: assert property (
        setup && !(i_paddr inside {8'he4, 8'hf8, 8'hfc})
        |=> o_pslverr && o_pready
            && ($past(i_pwrite) ? $stable(o_prdata) : o_prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_rtc_gate_pair: assert property (o_rtc_clock_enable != o_rtc_reset)
        else $error("rtc gate and reset disagree");
    chk_pin_mux_excl: assert property (
        o_converter_ext_clock |-> !o_second_general_pin_gpio_en)
        else $error("pin used as gpio and clock");
    chk_phase_needs_sync: assert property (
        o_converter_clock_phase_shift |-> o_converter_clock_sync)
        else $error("phase shift without sync");
    chk_track_core_on: assert property (
        o_linear_regulator_four_track |-> $past(i_core_supply_one_active))
        else $error("tracking while core one inactive");
    chk_off_event_pulse: assert property (
        off_wr |=> o_switch_off_event ##1 !o_switch_off_event)
        else $error("switch-off pulse wrong");
    chk_core_rst_off: assert property (o_core_reset_request |-> o_switch_off_event)
        else $error("core reset without switch-off");
    chk_wake_not_off: assert property (o_wake_up_event |-> !o_switch_off_event)
        else $error("wake-up with switch-off");

    cov_off_write: cover property (off_wr);
    cov_refused: cover property (o_pslverr);
    cov_wake: cover property (o_wake_up_event);
endmodule : pdc_control_regs_monitor

bind pdc_control_regs pdc_control_regs_monitor pdc_control_regs_monitor_inst (.*);

// ### verification/tb_pdc_control_regs.sv
`timescale 1ns/1ps

module tb_pdc_control_regs;
    import pdc_pkg::*;
    logic        i_clock, i_rst_n, i_turnoff_rst_n, i_psel, i_penable, i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, q;
    logic [3:0]  i_pstrb;
    logic [2:0]  i_boot_pulse_skip;
    logic [1:0]  o_backup_charge_voltage_select;
    logic [2:0]  ev;
    logic        o_pready, o_pslverr, i_boot_load, i_boot_slow_clock_source, i_boot_keep_on;
    logic        i_off_state, i_backup_state, i_core_supply_one_active, i_second_general_pin_in;
    logic        o_backup_charge_enable, o_linear_regulator_four_track, o_core_two_pulse_skip;
    logic        o_core_one_pulse_skip, o_io_converter_pulse_skip, o_second_general_pin_gpio_en;
    logic        o_converter_ext_clock, o_converter_clock_sync, o_converter_clock_phase_shift;
    logic        o_sequential_power_off, o_rtc_clock_enable, o_rtc_reset, e;
    logic        o_slow_clock_source_select, o_scaling_port_select, o_keep_on_request;
    logic        o_sleep_allow, o_switch_off_event, o_core_reset_request, o_wake_up_event;
    int          err_total, n_compared, cyc;

    pdc_control_regs pdc_control_regs_inst (.*);

    initial
    begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // Hang guard, far above the roughly 150 cycles the run needs
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            results();
        end
    end

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Leading edge keeps back-to-back calls from assigning twice in one step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge i_clock);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        i_pstrb   <= s;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do
        begin
            @(posedge i_clock);
        end while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(a, 1'b1, d, s);
        // Events stand the cycle after the write, levels one cycle later
        @(posedge i_clock);
        ev = {o_switch_off_event, o_core_reset_request, o_wake_up_event};
        @(posedge i_clock);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, 4'h0);
        check(q, exp);
    endtask : rdchk

    task automatic t_reset;
        rdchk(8'he4, 32'h00);
        rdchk(8'hf8, 32'h39);
        rdchk(8'hfc, 32'h10);
        check(o_second_general_pin_gpio_en, 32'h1);
        check(o_rtc_clock_enable, 32'h1);
    endtask : t_reset

    task automatic t_backup;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'he4, 32'hf8 | (c << 1) | (c & 1), 4'h1);
            check(o_backup_charge_voltage_select, c[1:0]);
            check(o_backup_charge_enable, c[0]);
            rdchk(8'he4, (c << 1) | (c & 1));
        end
    endtask : t_backup

    task automatic t_refuse;
        wr(8'he4, 32'h06, 4'h0);
        wr(8'he0, 32'hff, 4'h1);
        rdchk(8'he4, 32'h07);
        rdchk(8'h00, 32'h0);
        check(e, 32'h1);
        rdchk(8'he5, 32'h0);
        check(e, 32'h1);
    endtask : t_refuse

    task automatic t_conv;
        wr(8'hf8, 32'hff, 4'h1);
        rdchk(8'hf8, 32'h7f);
        check({o_core_two_pulse_skip, o_core_one_pulse_skip, o_io_converter_pulse_skip},
              32'h7);
        check({o_linear_regulator_four_track, o_converter_ext_clock}, 32'h3);
        check({o_second_general_pin_gpio_en, o_converter_clock_sync}, 32'h1);
        check(o_converter_clock_phase_shift, 32'h0);
        i_core_supply_one_active <= 1'b0;
        i_second_general_pin_in  <= 1'b0;
        repeat (2) @(posedge i_clock);
        check({o_linear_regulator_four_track, o_converter_ext_clock}, 32'h0);
        i_core_supply_one_active <= 1'b1;
        i_second_general_pin_in  <= 1'b1;
        wr(8'hf8, 32'h41, 4'h1);
        check({o_converter_clock_sync, o_converter_clock_phase_shift}, 32'h3);
        check({o_second_general_pin_gpio_en, o_converter_ext_clock}, 32'h2);
        wr(8'hf8, 32'h02, 4'h1);
        check({o_converter_clock_sync, o_converter_clock_phase_shift}, 32'h0);
        wr(8'hf8, 32'h47, 4'h1);
        i_turnoff_rst_n <= 1'b0;
        @(posedge i_clock);
        i_turnoff_rst_n <= 1'b1;
        rdchk(8'hf8, 32'h3f);
    endtask : t_conv

    task automatic t_events;
        wr(8'hfc, 32'h1b, 4'h1);
        check(ev[2:1], 32'h3);
        check(o_sleep_allow, 32'h0);
        rdchk(8'hfc, 32'h1b);
        i_off_state <= 1'b1;
        @(posedge i_clock);
        i_off_state <= 1'b0;
        rdchk(8'hfc, 32'h10);
        wr(8'hfc, 32'h12, 4'h1);
        check({o_sleep_allow, ev[0], ev[2]}, 32'h4);
        wr(8'hfc, 32'h10, 4'h1);
        check(ev[0], 32'h1);
        wr(8'hfc, 32'h11, 4'h1);
        check({ev[0], ev[2], ev[1]}, 32'h2);
        i_off_state <= 1'b1;
        @(posedge i_clock);
        i_off_state <= 1'b0;
    endtask : t_events

    task automatic t_boot;
        i_boot_pulse_skip        <= 3'h2;
        i_boot_slow_clock_source <= 1'b1;
        i_boot_keep_on           <= 1'b1;
        i_boot_load              <= 1'b1;
        @(posedge i_clock);
        i_boot_load <= 1'b0;
        rdchk(8'hf8, 32'h17);
        rdchk(8'hfc, 32'h34);
        check({o_core_two_pulse_skip, o_core_one_pulse_skip, o_io_converter_pulse_skip},
              32'h2);
        check({o_slow_clock_source_select, o_keep_on_request}, 32'h3);
    endtask : t_boot

    task automatic t_devctrl;
        wr(8'hfc, 32'hd4, 4'h1);
        check({o_sequential_power_off, o_rtc_reset, o_rtc_clock_enable}, 32'h6);
        check(o_scaling_port_select, 32'h1);
        wr(8'hfc, 32'hc0, 4'h1);
        check({o_scaling_port_select, o_keep_on_request}, 32'h0);
        i_backup_state <= 1'b1;
        i_rst_n        <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n        <= 1'b1;
        i_backup_state <= 1'b0;
        rdchk(8'hfc, 32'h50);
        rdchk(8'hf8, 32'h39);
    endtask : t_devctrl

    initial
    begin
        {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} = '0;
        {i_boot_load, i_boot_pulse_skip, i_boot_slow_clock_source, i_boot_keep_on} = '0;
        {i_off_state, i_backup_state} = '0;
        {i_turnoff_rst_n, i_core_supply_one_active, i_second_general_pin_in} = 3'h7;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_reset();
        t_backup();
        t_refuse();
        t_conv();
        t_events();
        t_boot();
        t_devctrl();
        results();
    end
endmodule : tb_pdc_control_regs
